// file: rtl/csr_core.sv
`timescale 1ns/10ps
// Summary of operation
// - Overflow flags A bit 15, B bit 14
// - Sticky saturation flags bits 13, 12
// - Bit 11 is OR of overflows
// - Bit 10 ORs sticky; clearing clears both
// - Bit 9 shows counted loop active
// - Half carry from bit 4 or 8
// - Priority is top bit over bits 7:5
// - Level 7 or top bit disables user irqs
// - Priority bits read-only when nesting disabled
// - Bit 4 shows repeat loop active
// - Negative flag follows result sign
// - Signed overflow flag on sign flip
// - Zero flag loads result zero when touched, else held
// - Carry flag on carry out of MSB
// - Control bit 15 latency mode, resets zero
// - Bits 13:12 select multiply signedness
// - Bit 11 write one ends loop; reads zero
// - Bits 10:8 report loop nesting depth
// - Bits 7, 6 enable accumulator saturation
// - Bit 5 data write saturation, resets one
// - Bit 4 selects super or normal saturation
// - Bit 3 top priority bit, clear only
// - Carry flags mean borrow on subtraction
// - Bit 1 selects biased or convergent rounding
// - Bit 0 selects integer or fractional multiply
module csr_core
   import csr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire csr_alu_t alu_upd,
   input wire csr_dsp_t dsp_upd,
   input wire csr_loop_t loop_st,
   input wire logic nesting_disable,
   input wire logic priority_low_wr,
   input wire logic [2:0] priority_low_val,
   input wire logic priority_top_set,
   output logic [15:0] reg_rdata,
   output logic early_loop_exit,
   output csr_ctl_t ctl_out
);
   logic acc_a_overflow_flag_r;
   logic acc_b_overflow_flag_r;
   logic acc_a_sticky_sat_flag_r;
   logic acc_b_sticky_sat_flag_r;
   logic counted_loop_active_r;
   logic repeat_active_r;
   logic [2:0] loop_nest_depth_r;
   logic stack_frame_active_r;
   logic half_carry_flag_r;
   logic [2:0] priority_low_bits_r;
   logic negative_flag_r;
   logic signed_wrap_flag_r;
   logic zero_flag_r;
   logic carry_flag_r;
   logic variable_latency_r;
   logic [1:0] multiply_sign_sel_r;
   logic acc_a_clip_enable_r;
   logic acc_b_clip_enable_r;
   logic memory_write_clip_enable_r;
   logic clip_mode_sel_r;
   logic priority_top_bit_r;
   logic rounding_sel_r;
   logic integer_mult_r;
   logic status_wr;
   logic control_wr;
   logic [15:0] status_word;
   logic [15:0] control_word;

   assign status_wr = reg_wr && (reg_addr == CSR_ADDR_STATUS);
   assign control_wr = reg_wr && (reg_addr == CSR_ADDR_CONTROL);

   function automatic logic [15:0] pack_status(
      input logic oa, input logic ob, input logic sa, input logic sb,
      input logic da, input logic dc, input logic [2:0] prio, input logic ra,
      input logic n, input logic ov, input logic z, input logic c);
      pack_status = {oa, ob, sa, sb, oa | ob, sa | sb, da, dc, prio, ra, n, ov, z, c};
   endfunction

   // Overflow flags track the DSP engine every cycle; a write still lands
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         acc_a_overflow_flag_r <= 1'b0;
         acc_b_overflow_flag_r <= 1'b0;
      end
      else if (status_wr)
      begin
         acc_a_overflow_flag_r <= reg_wdata[ST_OVF_A] | dsp_upd.acc_a_overflow;
         acc_b_overflow_flag_r <= reg_wdata[ST_OVF_B] | dsp_upd.acc_b_overflow;
      end
      else
      begin
         acc_a_overflow_flag_r <= dsp_upd.acc_a_overflow;
         acc_b_overflow_flag_r <= dsp_upd.acc_b_overflow;
      end
   end

   // Sticky flags: saturation event wins over a clearing write
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         acc_a_sticky_sat_flag_r <= 1'b0;
         acc_b_sticky_sat_flag_r <= 1'b0;
      end
      else if (status_wr && !reg_wdata[ST_SAT_ANY])
      begin
         // Clearing the combined bit clears both
         acc_a_sticky_sat_flag_r <= dsp_upd.acc_a_saturate;
         acc_b_sticky_sat_flag_r <= dsp_upd.acc_b_saturate;
      end
      else if (status_wr)
      begin
         acc_a_sticky_sat_flag_r <= reg_wdata[ST_SAT_A] | dsp_upd.acc_a_saturate;
         acc_b_sticky_sat_flag_r <= reg_wdata[ST_SAT_B] | dsp_upd.acc_b_saturate;
      end
      else
      begin
         acc_a_sticky_sat_flag_r <= acc_a_sticky_sat_flag_r | dsp_upd.acc_a_saturate;
         acc_b_sticky_sat_flag_r <= acc_b_sticky_sat_flag_r | dsp_upd.acc_b_saturate;
      end
   end

   // Loop status mirrors the sequencer, never software
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         counted_loop_active_r <= 1'b0;
         repeat_active_r <= 1'b0;
         loop_nest_depth_r <= 3'h0;
         stack_frame_active_r <= 1'b0;
      end
      else
      begin
         counted_loop_active_r <= loop_st.counted_active;
         repeat_active_r <= loop_st.repeat_active;
         loop_nest_depth_r <= loop_st.nest_depth;
         stack_frame_active_r <= loop_st.frame_active;
      end
   end

   // ALU flags: a result in the same cycle as a write overrides it
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         half_carry_flag_r <= 1'b0;
         negative_flag_r <= 1'b0;
         signed_wrap_flag_r <= 1'b0;
         carry_flag_r <= 1'b0;
      end
      else if (alu_upd.valid)
      begin
         // Borrow polarity is supplied by the ALU on subtraction
         half_carry_flag_r <= alu_upd.byte_op ? alu_upd.half_carry_b
                                              : alu_upd.half_carry_w;
         negative_flag_r <= alu_upd.negative;
         signed_wrap_flag_r <= alu_upd.signed_wrap;
         carry_flag_r <= alu_upd.carry_out;
      end
      else if (status_wr)
      begin
         half_carry_flag_r <= reg_wdata[ST_HALF];
         negative_flag_r <= reg_wdata[ST_NEG];
         signed_wrap_flag_r <= reg_wdata[ST_OVF];
         carry_flag_r <= reg_wdata[ST_CARRY];
      end
   end

   // Zero flag held between affecting results
   always_ff @(posedge clk)
   begin
      if (rst)
         zero_flag_r <= 1'b0;
      else if (alu_upd.valid && alu_upd.zero_touch)
         zero_flag_r <= alu_upd.result_zero;
      else if (status_wr)
         zero_flag_r <= reg_wdata[ST_ZERO];
   end

   // Priority low bits; hardware load takes precedence over software
   always_ff @(posedge clk)
   begin
      if (rst)
         priority_low_bits_r <= 3'h0;
      else if (priority_low_wr)
         priority_low_bits_r <= priority_low_val;
      else if (status_wr && !nesting_disable)
         priority_low_bits_r <= reg_wdata[ST_PRIO_HI:ST_PRIO_LO];
   end

   // Top priority bit: set by hardware, software may only clear
   always_ff @(posedge clk)
   begin
      if (rst)
         priority_top_bit_r <= 1'b0;
      else if (priority_top_set)
         priority_top_bit_r <= 1'b1;
      else if (control_wr && !reg_wdata[CT_PRIO_TOP])
         priority_top_bit_r <= 1'b0;
   end

   // Writable control fields
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         variable_latency_r <= CSR_CONTROL_RST[CT_VAR];
         multiply_sign_sel_r <= CSR_CONTROL_RST[CT_US_HI:CT_US_LO];
         acc_a_clip_enable_r <= CSR_CONTROL_RST[CT_ACC_A_CLIP_ENABLE];
         acc_b_clip_enable_r <= CSR_CONTROL_RST[CT_ACC_B_CLIP_ENABLE];
         memory_write_clip_enable_r <= CSR_CONTROL_RST[CT_MEMORY_WRITE_CLIP_ENABLE];
         clip_mode_sel_r <= CSR_CONTROL_RST[CT_CLIP_MODE_SEL];
         rounding_sel_r <= CSR_CONTROL_RST[CT_RND];
         integer_mult_r <= CSR_CONTROL_RST[CT_INT];
      end
      else if (control_wr)
      begin
         variable_latency_r <= reg_wdata[CT_VAR];
         multiply_sign_sel_r <= reg_wdata[CT_US_HI:CT_US_LO];
         acc_a_clip_enable_r <= reg_wdata[CT_ACC_A_CLIP_ENABLE];
         acc_b_clip_enable_r <= reg_wdata[CT_ACC_B_CLIP_ENABLE];
         memory_write_clip_enable_r <= reg_wdata[CT_MEMORY_WRITE_CLIP_ENABLE];
         clip_mode_sel_r <= reg_wdata[CT_CLIP_MODE_SEL];
         rounding_sel_r <= reg_wdata[CT_RND];
         integer_mult_r <= reg_wdata[CT_INT];
      end
   end

   // Early exit is a one-cycle pulse to the loop sequencer
   always_ff @(posedge clk)
   begin
      if (rst)
         early_loop_exit <= 1'b0;
      else
         early_loop_exit <= control_wr && reg_wdata[CT_EXIT];
   end

   assign status_word = pack_status(acc_a_overflow_flag_r, acc_b_overflow_flag_r,
      acc_a_sticky_sat_flag_r, acc_b_sticky_sat_flag_r, counted_loop_active_r,
      half_carry_flag_r, priority_low_bits_r, repeat_active_r, negative_flag_r,
      signed_wrap_flag_r, zero_flag_r, carry_flag_r);

   // Exit bit and bit 14 always read zero
   assign control_word = {variable_latency_r, 1'b0, multiply_sign_sel_r, 1'b0,
      loop_nest_depth_r, acc_a_clip_enable_r, acc_b_clip_enable_r,
      memory_write_clip_enable_r, clip_mode_sel_r, priority_top_bit_r,
      stack_frame_active_r, rounding_sel_r, integer_mult_r};

   // Read data valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (reg_rd && reg_addr == CSR_ADDR_STATUS)
         reg_rdata <= status_word;
      else if (reg_rd && reg_addr == CSR_ADDR_CONTROL)
         reg_rdata <= control_word;
      else
         reg_rdata <= 16'h0000;
   end

   // Decoded control registered so every output is a flop
   always_ff @(posedge clk)
   begin
      if (rst)
         ctl_out <= '0;
      else
      begin
         ctl_out.variable_latency <= variable_latency_r;
         ctl_out.multiply_sign_sel <= multiply_sign_sel_r;
         ctl_out.multiply_reserved <= &multiply_sign_sel_r;
         ctl_out.acc_a_clip_enable <= acc_a_clip_enable_r;
         ctl_out.acc_b_clip_enable <= acc_b_clip_enable_r;
         ctl_out.memory_write_clip_enable <= memory_write_clip_enable_r;
         ctl_out.clip_mode_sel <= clip_mode_sel_r;
         ctl_out.rounding_sel <= rounding_sel_r;
         ctl_out.integer_mult <= integer_mult_r;
         ctl_out.cpu_priority <= {priority_top_bit_r, priority_low_bits_r};
         ctl_out.user_irq_disable <= priority_top_bit_r
            || (priority_low_bits_r == CSR_PRIO_MAX_LOW);
      end
   end
endmodule

// file: rtl/csr_pkg.sv
package csr_pkg;
   // Register indices on the plain port
   localparam logic [3:0] CSR_ADDR_STATUS = 4'h0;
   localparam logic [3:0] CSR_ADDR_CONTROL = 4'h1;
   // Status word fields
   localparam int ST_OVF_A = 15;
   localparam int ST_OVF_B = 14;
   localparam int ST_SAT_A = 13;
   localparam int ST_SAT_B = 12;
   localparam int ST_OVF_ANY = 11;
   localparam int ST_SAT_ANY = 10;
   localparam int ST_LOOP = 9;
   localparam int ST_HALF = 8;
   localparam int ST_PRIO_HI = 7;
   localparam int ST_PRIO_LO = 5;
   localparam int ST_REP = 4;
   localparam int ST_NEG = 3;
   localparam int ST_OVF = 2;
   localparam int ST_ZERO = 1;
   localparam int ST_CARRY = 0;
   // Control word fields
   localparam int CT_VAR = 15;
   localparam int CT_US_HI = 13;
   localparam int CT_US_LO = 12;
   localparam int CT_EXIT = 11;
   localparam int CT_DL_HI = 10;
   localparam int CT_DL_LO = 8;
   localparam int CT_ACC_A_CLIP_ENABLE = 7;
   localparam int CT_ACC_B_CLIP_ENABLE = 6;
   localparam int CT_MEMORY_WRITE_CLIP_ENABLE = 5;
   localparam int CT_CLIP_MODE_SEL = 4;
   localparam int CT_PRIO_TOP = 3;
   localparam int CT_FRAME = 2;
   localparam int CT_RND = 1;
   localparam int CT_INT = 0;
   // Reset values
   localparam logic [15:0] CSR_STATUS_RST = 16'h0000;
   localparam logic [15:0] CSR_CONTROL_RST = 16'h0020;
   // Multiply sign selections; maximum low priority level
   localparam logic [1:0] CSR_US_SIGNED = 2'h0;
   localparam logic [1:0] CSR_US_UNSIGNED = 2'h1;
   localparam logic [1:0] CSR_US_MIXED = 2'h2;
   localparam logic [2:0] CSR_PRIO_MAX_LOW = 3'h7;

   // One ALU result update
   typedef struct packed {
      logic valid;
      logic byte_op;
      logic subtract;
      logic carry_out;
      logic half_carry_b;
      logic half_carry_w;
      logic negative;
      logic signed_wrap;
      logic zero_touch;
      logic result_zero;
   } csr_alu_t;

   // DSP engine accumulator events
   typedef struct packed {
      logic acc_a_overflow;
      logic acc_b_overflow;
      logic acc_a_saturate;
      logic acc_b_saturate;
   } csr_dsp_t;

   // Loop sequencer state
   typedef struct packed {
      logic counted_active;
      logic repeat_active;
      logic [2:0] nest_depth;
      logic frame_active;
   } csr_loop_t;

   // Decoded control for the datapath
   typedef struct packed {
      logic variable_latency;
      logic [1:0] multiply_sign_sel;
      logic acc_a_clip_enable;
      logic acc_b_clip_enable;
      logic memory_write_clip_enable;
      logic clip_mode_sel;
      logic rounding_sel;
      logic integer_mult;
      logic [3:0] cpu_priority;
      logic user_irq_disable;
      logic multiply_reserved;
   } csr_ctl_t;
endpackage

// file: sim/csr_core_sva.sv
`timescale 1ns/10ps
module csr_core_chk
   import csr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire csr_loop_t loop_st,
   input wire logic [15:0] reg_rdata,
   input wire logic early_loop_exit,
   input wire csr_ctl_t ctl_out
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   chk_unmapped_zero: assert property (
      $past(reg_rd) && $past(reg_addr) > CSR_ADDR_CONTROL |-> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_exit_pulse: assert property (
      early_loop_exit == ($past(reg_wr) && $past(reg_addr) == CSR_ADDR_CONTROL
      && $past(reg_wdata[CT_EXIT]))) else $error("early exit pulse wrong");
   chk_ovf_or: assert property (
      $past(reg_rd) && $past(reg_addr) == CSR_ADDR_STATUS
      |-> reg_rdata[ST_OVF_ANY] == (reg_rdata[ST_OVF_A] | reg_rdata[ST_OVF_B]))
      else $error("combined overflow wrong");
   chk_sat_or: assert property (
      $past(reg_rd) && $past(reg_addr) == CSR_ADDR_STATUS
      |-> reg_rdata[ST_SAT_ANY] == (reg_rdata[ST_SAT_A] | reg_rdata[ST_SAT_B]))
      else $error("combined sticky wrong");
   chk_ctl_zeros: assert property (
      $past(reg_rd) && $past(reg_addr) == CSR_ADDR_CONTROL
      |-> reg_rdata[14] == 1'b0 && reg_rdata[CT_EXIT] == 1'b0)
      else $error("control zero bits set");
   // Loop state must be steady long enough to reach the register
   chk_loop_flags: assert property (
      $past(reg_rd) && $past(reg_addr) == CSR_ADDR_STATUS && !$past(rst, 2)
      && $past(loop_st, 2) == loop_st |-> reg_rdata[ST_LOOP] == loop_st.counted_active
      && reg_rdata[ST_REP] == loop_st.repeat_active) else $error("loop flags wrong");
   chk_loop_depth: assert property (
      $past(reg_rd) && $past(reg_addr) == CSR_ADDR_CONTROL && !$past(rst, 2)
      && $past(loop_st, 2) == loop_st |-> reg_rdata[CT_DL_HI:CT_DL_LO] == loop_st.nest_depth)
      else $error("loop depth wrong");
   chk_irq_disable: assert property (
      ctl_out.user_irq_disable == (ctl_out.cpu_priority[3] || ctl_out.cpu_priority[2:0] == 3'h7))
      else $error("user irq disable wrong");
   chk_mul_resv: assert property (
      ctl_out.multiply_reserved == (ctl_out.multiply_sign_sel == 2'h3))
      else $error("reserved sign select wrong");
endmodule

// file: sim/tb.sv
`timescale 1ns/10ps
module tb;
   import csr_pkg::*;
   logic clk, rst, reg_wr, reg_rd, nesting_disable, priority_low_wr, priority_top_set;
   logic early_loop_exit;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, st_m, ct_m, q;
   logic [2:0] priority_low_val;
   logic [1:0] hb;
   csr_alu_t alu_upd, av;
   csr_dsp_t dsp_upd, dv;
   csr_loop_t loop_st;
   csr_ctl_t ctl_out, ce;
   int error_cnt, checks_done;
   csr_core dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .alu_upd(alu_upd), .dsp_upd(dsp_upd),
      .loop_st(loop_st), .nesting_disable(nesting_disable),
      .priority_low_wr(priority_low_wr), .priority_low_val(priority_low_val),
      .priority_top_set(priority_top_set), .reg_rdata(reg_rdata),
      .early_loop_exit(early_loop_exit), .ctl_out(ctl_out));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [15:0] exp_st();
      logic [15:0] s;
      s = st_m;
      {s[15], s[14]} = {dsp_upd.acc_a_overflow, dsp_upd.acc_b_overflow};
      s[11] = s[15] | s[14];
      s[10] = s[13] | s[12];
      {s[9], s[4]} = {loop_st.counted_active, loop_st.repeat_active};
      return s;
   endfunction
   function automatic logic [15:0] exp_ct();
      logic [15:0] c;
      c = ct_m;
      c[10:8] = loop_st.nest_depth;
      c[2] = loop_st.frame_active;
      return c;
   endfunction
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      // Top priority bit may only be cleared by software
      if (a == CSR_ADDR_CONTROL)
         ct_m = (d & 16'hB0F3) | (ct_m & d & 16'h0008);
      else if (a == CSR_ADDR_STATUS)
      begin
         st_m[13:12] = d[10] ? d[13:12] : 2'b00;
         if (!nesting_disable)
            st_m[7:5] = d[7:5];
         {st_m[8], st_m[3:0]} = {d[8], d[3:0]};
      end
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      complete_run();
   end
   initial
   begin
      rst = 1'b1;
      {reg_wr, reg_rd, nesting_disable, priority_low_wr, priority_top_set} = 5'h00;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      priority_low_val = 3'h0;
      alu_upd = '0;
      dsp_upd = '0;
      loop_st = '0;
      st_m = CSR_STATUS_RST;
      ct_m = CSR_CONTROL_RST;
      error_cnt = 0;
      checks_done = 0;
      void'($urandom(2883));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(CSR_ADDR_STATUS);
      chk(q, exp_st());
      rd(CSR_ADDR_CONTROL);
      chk(q, exp_ct());
      for (int k = 0; k < 24; k++)
      begin
         @(posedge clk);
         loop_st <= csr_loop_t'(6'($urandom));
         nesting_disable <= 1'($urandom);
         dv = csr_dsp_t'(4'($urandom));
         dsp_upd <= dv;
         @(posedge clk);
         dsp_upd <= {dv[3:2], 2'b00};
         // Sticky flags survive the end of saturation
         st_m[13:12] = st_m[13:12] | dv[1:0];
         rd(CSR_ADDR_STATUS);
         chk(q, exp_st());
         av = csr_alu_t'(10'($urandom));
         av.valid = 1'b1;
         @(posedge clk);
         alu_upd <= av;
         @(posedge clk);
         alu_upd <= '0;
         st_m[0] = av.carry_out;
         st_m[8] = av.byte_op ? av.half_carry_b : av.half_carry_w;
         {st_m[3], st_m[2]} = {av.negative, av.signed_wrap};
         if (av.zero_touch)
            st_m[1] = av.result_zero;
         rd(CSR_ADDR_STATUS);
         chk(q, exp_st());
         wr(CSR_ADDR_CONTROL, 16'($urandom));
         wr(CSR_ADDR_STATUS, 16'($urandom) & 16'h3FFF);
         hb = 2'($urandom);
         @(posedge clk);
         {priority_low_wr, priority_top_set} <= hb;
         priority_low_val <= 3'($urandom);
         @(posedge clk);
         {priority_low_wr, priority_top_set} <= 2'b00;
         if (hb[1])
            st_m[7:5] = priority_low_val;
         if (hb[0])
            ct_m[3] = 1'b1;
         rd(CSR_ADDR_STATUS);
         chk(q, exp_st());
         rd(CSR_ADDR_CONTROL);
         chk(q, exp_ct());
         rd(4'(2 + $urandom % 14));
         chk(q, 16'h0000);
         wr(4'(2 + $urandom % 14), 16'($urandom));
         ce = {ct_m[15], ct_m[13:12], ct_m[7:4], ct_m[1:0], ct_m[3], st_m[7:5],
            ct_m[3] | (st_m[7:5] == CSR_PRIO_MAX_LOW), ct_m[13:12] == 2'h3};
         // Step off the edge so the output has settled
         #1;
         chk(16'(ctl_out), 16'(ce));
      end
      rd(CSR_ADDR_CONTROL);
      chk(q, exp_ct());
      complete_run();
   end
endmodule
bind csr_core csr_core_chk chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .loop_st(loop_st),
   .reg_rdata(reg_rdata), .early_loop_exit(early_loop_exit), .ctl_out(ctl_out));
